// File: hdl/hub_string_feature_regs.sv
// Overview of operation
// [RULE_01] Reserved length and feature bits read zero.
// [RULE_02] Length field bits six:zero, resets zero.
// [RULE_03] Product text length never exceeds sixty-four.
// [RULE_04] Length writable only with custom text enabled.
// [RULE_05] Nonzero length streams that many bytes, index three.
// [RULE_06] Bit five reports version three zero.
// [RULE_07] High-speed-only drops 5G speed, disables USB3.
// [RULE_08] Bits 4,2,1,0 read and act as fuse OR.
// [RULE_09] Bit three enables downstream unconfigured state.
// [RULE_10] Bit two slows host two-wire rate to 100k.
// [RULE_11] EEPROM rate 400k unless fuse selects 100k.
// [RULE_12] Bit one drops vendor mode from automatic sequence.
// [RULE_13] Bit zero tries all dividers, highest first.
`timescale 1ns/1ps
`default_nettype none
module hub_string_feature_regs
(
   input  wire logic                       CLK,
   input  wire logic                       RESET_N,
   input  wire logic                       CE,
   input  wire logic                       CUSTOM_TEXT_EN,
   input  wire logic                       REG_WR,
   input  wire logic                       REG_RD,
   input  wire logic [7:0]                 REG_ADDR,
   input  wire logic [7:0]                 REG_WDATA,
   output logic      [7:0]                 REG_RDATA,
   output logic                            REG_RVALID,
   input  wire logic [7:0]                 FUSE_BITS,
   input  wire logic                       FUSE_EEPROM_SLOW,
   input  wire logic                       STR_REQ,
   input  wire logic [7:0]                 STR_INDEX,
   output logic      [7:0]                 DATA_ADDR,
   input  wire logic [7:0]                 DATA_BYTE,
   output logic      [7:0]                 STR_BYTE,
   output logic                            STR_VALID,
   output logic                            STR_LAST,
   output logic                            STR_NONE,
   output logic      [15:0]                BCD_USB,
   output logic                            SPEED_5G_ADVERTISE,
   output logic                            USB3_HUB_ENABLE,
   output logic                            DOWNSTREAM_UNCONFIGURED_ENABLE,
   output logic                            TWO_WIRE_TICK,
   output logic                            EEPROM_TICK,
   input  wire logic                       AUTOMODE_EN,
   input  wire logic                       CHARGE_START,
   input  wire logic                       CHARGE_NEXT,
   output var hub_cfg_pkg::charge_mode_t   CHARGE_MODE
);

   // ------------------------------------------------------------------
   // Register storage and effective feature view
   // ------------------------------------------------------------------
   logic [6:0]                product_text_length_ff;
   logic [7:0]                feature_config_three_ff;
   logic [7:0]                feature_read;
   hub_cfg_pkg::feature_eff_t eff;
   logic [6:0]                nxt_length;

   // Fuse bits are OR'ed onto the bits that have a fuse twin; others pass straight.
   assign feature_read = (feature_config_three_ff | (FUSE_BITS & hub_cfg_pkg::FUSE_OR_MASK))
                         & hub_cfg_pkg::FEATURE_WR_MASK; // RULE_08
   assign eff.ver30     = feature_read[hub_cfg_pkg::VER30_BIT];
   assign eff.hs_only   = feature_read[hub_cfg_pkg::HS_ONLY_BIT];
   assign eff.unconf    = feature_read[hub_cfg_pkg::UNCONF_BIT];
   assign eff.slow      = feature_read[hub_cfg_pkg::SLOW_BIT];
   assign eff.no_vendor = feature_read[hub_cfg_pkg::NO_VENDOR_BIT];
   assign eff.all_div   = feature_read[hub_cfg_pkg::ALL_DIV_BIT];

   // Oversized lengths are clamped so a descriptor never runs past the data.
   assign nxt_length = (REG_WDATA[hub_cfg_pkg::PROD_LEN_MSB:0] > hub_cfg_pkg::PROD_LEN_MAX)
                       ? hub_cfg_pkg::PROD_LEN_MAX
                       : REG_WDATA[hub_cfg_pkg::PROD_LEN_MSB:0]; // RULE_03

   // ------------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------------
   // The length register accepts loads only while custom text is enabled.
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
         product_text_length_ff <= hub_cfg_pkg::PROD_LEN_RESET[6:0]; // RULE_02
      else if (CE && REG_WR && CUSTOM_TEXT_EN &&
               REG_ADDR == hub_cfg_pkg::PROD_LEN_OFFSET) // RULE_04
         product_text_length_ff <= nxt_length;
   end

   // The feature register stores only its six defined bits.
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
         feature_config_three_ff <= hub_cfg_pkg::FEATURE_RESET;
      else if (CE && REG_WR && REG_ADDR == hub_cfg_pkg::FEATURE_OFFSET)
         feature_config_three_ff <= REG_WDATA & hub_cfg_pkg::FEATURE_WR_MASK; // RULE_01
   end

   // ------------------------------------------------------------------
   // Register reads
   // ------------------------------------------------------------------
   // Read data follows the strobe by one cycle; unmapped offsets read zero.
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         REG_RDATA  <= 8'h00;
         REG_RVALID <= 1'b0;
      end
      else if (CE)
      begin
         REG_RVALID <= REG_RD;
         if (REG_RD)
         begin
            if (REG_ADDR == hub_cfg_pkg::PROD_LEN_OFFSET)
               REG_RDATA <= {1'b0, product_text_length_ff}; // RULE_01
            else if (REG_ADDR == hub_cfg_pkg::FEATURE_OFFSET)
               REG_RDATA <= feature_read; // RULE_08
            else
               REG_RDATA <= 8'h00;
         end
      end
   end

   // ------------------------------------------------------------------
   // Feature outputs
   // ------------------------------------------------------------------
   // Static feature effects are registered straight onto the outputs.
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         BCD_USB                        <= hub_cfg_pkg::BCD_THREE_TWO;
         SPEED_5G_ADVERTISE             <= 1'b1;
         USB3_HUB_ENABLE                <= 1'b1;
         DOWNSTREAM_UNCONFIGURED_ENABLE <= 1'b0;
      end
      else if (CE)
      begin
         BCD_USB <= eff.ver30 ? hub_cfg_pkg::BCD_THREE_ZERO
                              : hub_cfg_pkg::BCD_THREE_TWO; // RULE_06
         SPEED_5G_ADVERTISE             <= !eff.hs_only; // RULE_07
         USB3_HUB_ENABLE                <= !eff.hs_only; // RULE_07
         DOWNSTREAM_UNCONFIGURED_ENABLE <= eff.unconf;   // RULE_09
      end
   end

   // ------------------------------------------------------------------
   // Serial clock rate tick generators
   // ------------------------------------------------------------------
   logic [11:0] two_wire_cnt_ff;
   logic [11:0] eeprom_cnt_ff;
   logic [11:0] two_wire_limit;
   logic [11:0] eeprom_limit;

   assign two_wire_limit = eff.slow ? hub_cfg_pkg::SLOW_CYCLES
                                    : hub_cfg_pkg::FAST_CYCLES; // RULE_10
   assign eeprom_limit   = FUSE_EEPROM_SLOW ? hub_cfg_pkg::SLOW_CYCLES
                                            : hub_cfg_pkg::FAST_CYCLES; // RULE_11

   // Host-request two-wire master tick, one pulse per bit period.
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         two_wire_cnt_ff <= 12'h000;
         TWO_WIRE_TICK   <= 1'b0;
      end
      else if (CE)
      begin
         TWO_WIRE_TICK <= (two_wire_cnt_ff >= two_wire_limit - 12'h001);
         if (two_wire_cnt_ff >= two_wire_limit - 12'h001)
            two_wire_cnt_ff <= 12'h000; // RULE_10
         else
            two_wire_cnt_ff <= two_wire_cnt_ff + 12'h001;
      end
   end

   // EEPROM load tick, one pulse per bit period.
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         eeprom_cnt_ff <= 12'h000;
         EEPROM_TICK   <= 1'b0;
      end
      else if (CE)
      begin
         EEPROM_TICK <= (eeprom_cnt_ff >= eeprom_limit - 12'h001);
         if (eeprom_cnt_ff >= eeprom_limit - 12'h001)
            eeprom_cnt_ff <= 12'h000; // RULE_11
         else
            eeprom_cnt_ff <= eeprom_cnt_ff + 12'h001;
      end
   end

   // ------------------------------------------------------------------
   // Product string streamer
   // ------------------------------------------------------------------
   hub_cfg_pkg::str_state_t str_state_ff;
   logic [6:0]              str_left_ff;

   // Each byte takes two cycles: address out, then data captured and sent.
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         str_state_ff <= hub_cfg_pkg::STR_IDLE;
         str_left_ff  <= 7'h00;
         DATA_ADDR    <= hub_cfg_pkg::PROD_DATA_BASE;
         STR_BYTE     <= 8'h00;
         STR_VALID    <= 1'b0;
         STR_LAST     <= 1'b0;
         STR_NONE     <= 1'b0;
      end
      else if (CE)
      begin
         STR_VALID <= 1'b0;
         STR_LAST  <= 1'b0;
         STR_NONE  <= 1'b0;
         case (str_state_ff)
            hub_cfg_pkg::STR_IDLE:
            begin
               if (STR_REQ && STR_INDEX == hub_cfg_pkg::PRODUCT_STRING_INDEX)
               begin
                  DATA_ADDR <= hub_cfg_pkg::PROD_DATA_BASE;
                  if (product_text_length_ff == 7'h00)
                     STR_NONE <= 1'b1; // RULE_05
                  else
                  begin
                     str_left_ff  <= product_text_length_ff; // RULE_05
                     str_state_ff <= hub_cfg_pkg::STR_FETCH;
                  end
               end
            end
            hub_cfg_pkg::STR_FETCH:
               str_state_ff <= hub_cfg_pkg::STR_SEND;
            hub_cfg_pkg::STR_SEND:
            begin
               STR_BYTE    <= DATA_BYTE;
               STR_VALID   <= 1'b1;
               STR_LAST    <= (str_left_ff == 7'h01); // RULE_05
               str_left_ff <= str_left_ff - 7'h01;
               DATA_ADDR   <= DATA_ADDR + 8'h01;
               if (str_left_ff == 7'h01)
                  str_state_ff <= hub_cfg_pkg::STR_IDLE;
               else
                  str_state_ff <= hub_cfg_pkg::STR_FETCH;
            end
            default:
               str_state_ff <= hub_cfg_pkg::STR_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Automatic charging mode sequencer
   // ------------------------------------------------------------------
   hub_cfg_pkg::charge_mode_t nxt_mode;

   // Picks the next mode after a failed attempt of the current one.
   always_comb
   begin
      nxt_mode = hub_cfg_pkg::CHG_DEDICATED;
      case (CHARGE_MODE)
         hub_cfg_pkg::CHG_DIV_HIGH:
            nxt_mode = eff.all_div ? hub_cfg_pkg::CHG_DIV_MID       // RULE_13
                     : (eff.no_vendor ? hub_cfg_pkg::CHG_DEDICATED
                                      : hub_cfg_pkg::CHG_VENDOR);
         hub_cfg_pkg::CHG_DIV_MID:
            nxt_mode = hub_cfg_pkg::CHG_DIV_LOW;                     // RULE_13
         hub_cfg_pkg::CHG_DIV_LOW:
            nxt_mode = eff.no_vendor ? hub_cfg_pkg::CHG_DEDICATED
                                     : hub_cfg_pkg::CHG_VENDOR;      // RULE_12
         hub_cfg_pkg::CHG_VENDOR:
            nxt_mode = hub_cfg_pkg::CHG_DEDICATED;
         default:
            nxt_mode = hub_cfg_pkg::CHG_DEDICATED;
      endcase
   end

   // Starts at the highest-current divider and steps on each failure.
   always_ff @(posedge CLK)
   begin
      if (!RESET_N)
         CHARGE_MODE <= hub_cfg_pkg::CHG_IDLE;
      else if (CE)
      begin
         if (!AUTOMODE_EN)
            CHARGE_MODE <= hub_cfg_pkg::CHG_IDLE;
         else if (CHARGE_START)
            CHARGE_MODE <= hub_cfg_pkg::CHG_DIV_HIGH; // RULE_13
         else if (CHARGE_NEXT && CHARGE_MODE != hub_cfg_pkg::CHG_IDLE)
            CHARGE_MODE <= nxt_mode;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   chk_len_reserved_zero: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_01
      REG_RVALID && $past(REG_ADDR) == hub_cfg_pkg::PROD_LEN_OFFSET |-> !REG_RDATA[7])
      else $error("Length reserved bit read nonzero.");
   chk_feat_reserved_zero: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_01
      REG_RVALID && $past(REG_ADDR) == hub_cfg_pkg::FEATURE_OFFSET
      |-> REG_RDATA[7:6] == 2'b00)
      else $error("Feature reserved bits read nonzero.");
   chk_len_max_bound: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_03
      product_text_length_ff <= hub_cfg_pkg::PROD_LEN_MAX)
      else $error("Product length above limit.");
   chk_len_write_lock: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_04
      CE && REG_WR && !CUSTOM_TEXT_EN |=> $stable(product_text_length_ff))
      else $error("Length changed while locked.");
   chk_none_on_zero: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_05
      CE && str_state_ff == hub_cfg_pkg::STR_IDLE && STR_REQ
      && STR_INDEX == hub_cfg_pkg::PRODUCT_STRING_INDEX && product_text_length_ff == 7'h00
      |=> STR_NONE && str_state_ff == hub_cfg_pkg::STR_IDLE)
      else $error("Empty product string not reported.");
   chk_single_byte_last: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_05
      CE && str_state_ff == hub_cfg_pkg::STR_IDLE && STR_REQ
      && STR_INDEX == hub_cfg_pkg::PRODUCT_STRING_INDEX && product_text_length_ff == 7'h01
      ##1 CE [*2] |=> STR_VALID && STR_LAST)
      else $error("One-byte string not ended on its byte.");
   chk_version_report: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_06
      CE && eff.ver30 |=> BCD_USB == hub_cfg_pkg::BCD_THREE_ZERO)
      else $error("Version three zero not reported.");
   chk_hs_only_speed: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_07
      CE && feature_config_three_ff[hub_cfg_pkg::HS_ONLY_BIT] |=> !SPEED_5G_ADVERTISE
      && !USB3_HUB_ENABLE)
      else $error("High-speed-only hub still advertises 5G.");
   chk_fuse_or_read: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_08
      CE && REG_RD && REG_ADDR == hub_cfg_pkg::FEATURE_OFFSET && FUSE_BITS[hub_cfg_pkg::SLOW_BIT]
      |=> REG_RDATA[hub_cfg_pkg::SLOW_BIT])
      else $error("Fuse bit missing from read value.");
   chk_slow_tick_period: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_10
      CE && eff.slow && two_wire_cnt_ff == hub_cfg_pkg::SLOW_CYCLES - 12'h001
      |=> TWO_WIRE_TICK && two_wire_cnt_ff == 12'h000)
      else $error("Slow two-wire tick missing at end of count.");
   chk_vendor_skipped: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_12
      CE && AUTOMODE_EN && !CHARGE_START && CHARGE_NEXT && eff.no_vendor
      && CHARGE_MODE == hub_cfg_pkg::CHG_DIV_LOW |=> CHARGE_MODE == hub_cfg_pkg::CHG_DEDICATED)
      else $error("Vendor mode not excluded.");
   chk_divider_order: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_13
      CE && AUTOMODE_EN && !CHARGE_START && CHARGE_NEXT && eff.all_div
      && CHARGE_MODE == hub_cfg_pkg::CHG_DIV_HIGH |=> CHARGE_MODE == hub_cfg_pkg::CHG_DIV_MID)
      else $error("Divider modes out of order.");

endmodule
`default_nettype wire

// File: pkg/hub_cfg_pkg.sv
`default_nettype none
package hub_cfg_pkg;

   // ------------------------------------------------------------------
   // Register offsets and reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] PROD_LEN_OFFSET = 8'h24;
   localparam logic [7:0] FEATURE_OFFSET  = 8'h25;
   localparam logic [7:0] PROD_DATA_BASE  = 8'h90;
   localparam logic [7:0] PROD_LEN_RESET  = 8'h00;
   localparam logic [7:0] FEATURE_RESET   = 8'h00;

   // ------------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------------
   localparam int         PROD_LEN_MSB    = 6;
   localparam logic [6:0] PROD_LEN_MAX    = 7'h40;
   localparam int         VER30_BIT       = 5;
   localparam int         HS_ONLY_BIT     = 4;
   localparam int         UNCONF_BIT      = 3;
   localparam int         SLOW_BIT        = 2;
   localparam int         NO_VENDOR_BIT   = 1;
   localparam int         ALL_DIV_BIT     = 0;
   localparam logic [7:0] FEATURE_WR_MASK = 8'h3F;
   localparam logic [7:0] FUSE_OR_MASK    = 8'h17;

   // ------------------------------------------------------------------
   // Descriptor constants
   // ------------------------------------------------------------------
   localparam logic [7:0]  PRODUCT_STRING_INDEX = 8'h03;
   localparam logic [15:0] BCD_THREE_ZERO       = 16'h0300;
   localparam logic [15:0] BCD_THREE_TWO        = 16'h0320;

   // ------------------------------------------------------------------
   // Timing: serial clock periods against a 5 ns core clock
   // ------------------------------------------------------------------
   localparam int          CLK_PERIOD_PS   = 5000;
   localparam int          SLOW_PERIOD_NS  = 10000;
   localparam int          FAST_PERIOD_NS  = 2500;
   localparam logic [11:0] SLOW_CYCLES     = 12'((SLOW_PERIOD_NS * 1000) / CLK_PERIOD_PS);
   localparam logic [11:0] FAST_CYCLES     = 12'((FAST_PERIOD_NS * 1000) / CLK_PERIOD_PS);

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {CHG_IDLE, CHG_DIV_HIGH, CHG_DIV_MID, CHG_DIV_LOW,
                             CHG_VENDOR, CHG_DEDICATED} charge_mode_t;

   typedef enum logic [1:0] {STR_IDLE, STR_FETCH, STR_SEND} str_state_t;

   typedef struct packed {
      logic ver30;
      logic hs_only;
      logic unconf;
      logic slow;
      logic no_vendor;
      logic all_div;
   } feature_eff_t;

endpackage
`default_nettype wire

// File: testbench/str_data_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Product text data store
// ------------------------------------------------------------------
module str_data_model
(
   input  wire logic       CLK,
   input  wire logic [7:0] DATA_ADDR,
   output logic      [7:0] DATA_BYTE
);
   // Answers one cycle after the address moves; off the store the byte toggles.
   always_ff @(posedge CLK)
   begin
      if (DATA_ADDR >= 8'h90 && DATA_ADDR <= 8'hCF)
         DATA_BYTE <= 8'h30 + (DATA_ADDR - 8'h90);
      else
         DATA_BYTE <= ~DATA_BYTE;
   end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                      clk, reset_n, custom_en, reg_wr, reg_rd, fuse_slow;
   logic                      str_req, auto_en, chg_start, chg_next;
   logic [7:0]                reg_addr, reg_wdata, fuse_bits, str_index, data_addr;
   logic [7:0]                data_byte, reg_rdata, str_byte;
   logic                      reg_rvalid, str_valid, str_last, str_none, spd5g, usb3_en;
   logic                      unconf, tw_tick, ee_tick, ce;
   logic [15:0]               bcd_usb;
   hub_cfg_pkg::charge_mode_t chg_mode;
   int                        n_mismatch, cmp_count;

   // ------------------------------------------------------------------
   // Clock, design and data store
   // ------------------------------------------------------------------
   // Free running 200 MHz clock.
   always #2.5 clk = ~clk;

   hub_string_feature_regs u_hub_string_feature_regs
   (
      .CLK(clk), .RESET_N(reset_n), .CE(ce), .CUSTOM_TEXT_EN(custom_en),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .FUSE_BITS(fuse_bits),
      .FUSE_EEPROM_SLOW(fuse_slow), .STR_REQ(str_req), .STR_INDEX(str_index),
      .DATA_ADDR(data_addr), .DATA_BYTE(data_byte), .STR_BYTE(str_byte),
      .STR_VALID(str_valid), .STR_LAST(str_last), .STR_NONE(str_none),
      .BCD_USB(bcd_usb), .SPEED_5G_ADVERTISE(spd5g), .USB3_HUB_ENABLE(usb3_en),
      .DOWNSTREAM_UNCONFIGURED_ENABLE(unconf), .TWO_WIRE_TICK(tw_tick),
      .EEPROM_TICK(ee_tick), .AUTOMODE_EN(auto_en), .CHARGE_START(chg_start),
      .CHARGE_NEXT(chg_next), .CHARGE_MODE(chg_mode)
   );

   str_data_model u_str_data_model (.CLK(clk), .DATA_ADDR(data_addr), .DATA_BYTE(data_byte));

   // ------------------------------------------------------------------
   // Reporting and bus tasks
   // ------------------------------------------------------------------
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_mode(input string what, input hub_cfg_pkg::charge_mode_t exp,
                           input hub_cfg_pkg::charge_mode_t got);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %s seen %s", what, exp.name(), got.name());
      end
   endtask

   // The register bus tasks start and end just after a falling edge, one idle cycle after the strobe; pulse ends on the first falling edge.
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      @(negedge clk);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      int         i;
      logic [7:0] d;
      d = 8'hXX;
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      for (i = 0; i < 3 && reg_rvalid !== 1'b1; i++)
         @(negedge clk);
      if (reg_rvalid === 1'b1)
         d = reg_rdata;
      chk_val(what, {8'h00, exp}, {8'h00, d});
      @(negedge clk);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_regs();
      rd_chk("length reset", 8'h24, 8'h00);
      rd_chk("feature reset", 8'h25, 8'h00);
      rd_chk("unmapped read", 8'h30, 8'h00);
      chk_val("version reset", 16'h0320, bcd_usb);
      reg_write(8'h24, 8'h15);
      rd_chk("locked length", 8'h24, 8'h00);
      custom_en = 1'b1;
      reg_write(8'h24, 8'hFF);
      rd_chk("clamped length", 8'h24, 8'h40);
      reg_write(8'h24, 8'h85);
      rd_chk("length bit seven", 8'h24, 8'h05);
      reg_write(8'h25, 8'hFF);
      rd_chk("feature top bits", 8'h25, 8'h3F);
      chk_val("version", 16'h0300, bcd_usb);
      chk_val("5G advertise", 16'h0000, {15'h0000, spd5g});
      chk_val("usb3 enable", 16'h0000, {15'h0000, usb3_en});
      chk_val("unconfigured", 16'h0001, {15'h0000, unconf});
      reg_write(8'h25, 8'h00);
      fuse_bits = 8'hE8;
      rd_chk("unused fuses", 8'h25, 8'h00);
      chk_val("unconfigured off", 16'h0000, {15'h0000, unconf});
      fuse_bits = 8'h17;
      rd_chk("fuse or", 8'h25, 8'h17);
      chk_val("fuse 5G", 16'h0000, {15'h0000, spd5g});
      fuse_bits = 8'h00;
   endtask

   // Writes made while the clock enable is low must not land.
   task automatic t_freeze();
      ce = 1'b0;
      reg_write(8'h25, 8'h20);
      ce = 1'b1;
      rd_chk("frozen write", 8'h25, 8'h00);
      chk_val("frozen version", 16'h0320, bcd_usb);
   endtask

   // A reset in mid-run returns both registers and the outputs to idle.
   task automatic t_reset();
      reg_write(8'h24, 8'h05);
      reg_write(8'h25, 8'h30);
      reset_n = 1'b0;
      @(negedge clk);
      reset_n = 1'b1;
      chk_val("reset version", 16'h0320, bcd_usb);
      chk_val("reset 5G", 16'h0001, {15'h0000, spd5g});
      rd_chk("reset length", 8'h24, 8'h00);
      rd_chk("reset feature", 8'h25, 8'h00);
   endtask

   task automatic str_run(input logic [7:0] idx, input int len);
      int i, n, nones;
      n = 0;
      nones = 0;
      str_index = idx;
      pulse(str_req);
      for (i = 0; i < 2 * len + 8; i++)
      begin
         if (str_valid === 1'b1)
         begin
            chk_val("string byte", 16'(8'h30 + n), {8'h00, str_byte});
            n++;
            chk_val("last flag", 16'(n == len), {15'h0000, str_last});
         end
         if (str_none === 1'b1)
            nones++;
         @(negedge clk);
      end
      chk_val("byte count", 16'(len), 16'(n));
      chk_val("none pulse", 16'(idx == 8'h03 && len == 0), 16'(nones));
   endtask

   task automatic t_string();
      reg_write(8'h24, 8'h03);
      str_run(8'h03, 3);
      str_run(8'h03, 3);
      str_run(8'h02, 0);
      reg_write(8'h24, 8'h01);
      str_run(8'h03, 1);
      reg_write(8'h24, 8'h40);
      str_run(8'h03, 64);
      reg_write(8'h24, 8'h00);
      str_run(8'h03, 0);
   endtask

   task automatic chg_seq(input logic [1:0] bits);
      hub_cfg_pkg::charge_mode_t exp[$];
      int                        i;
      exp.push_back(hub_cfg_pkg::CHG_DIV_HIGH);
      if (bits[0])
      begin
         exp.push_back(hub_cfg_pkg::CHG_DIV_MID);
         exp.push_back(hub_cfg_pkg::CHG_DIV_LOW);
      end
      if (!bits[1])
         exp.push_back(hub_cfg_pkg::CHG_VENDOR);
      exp.push_back(hub_cfg_pkg::CHG_DEDICATED);
      exp.push_back(hub_cfg_pkg::CHG_DEDICATED);
      reg_write(8'h25, {6'h00, bits});
      auto_en = 1'b1;
      pulse(chg_next);
      chk_mode("next in idle", hub_cfg_pkg::CHG_IDLE, chg_mode);
      pulse(chg_start);
      for (i = 0; i < exp.size(); i++)
      begin
         chk_mode("charge step", exp[i], chg_mode);
         pulse(chg_next);
         @(negedge clk);
      end
      auto_en = 1'b0;
      @(negedge clk);
      chk_mode("charge off", hub_cfg_pkg::CHG_IDLE, chg_mode);
   endtask

   task automatic tick_gap(input string what, input bit sel, input int exp);
      int i, gap, seen;
      gap = 0;
      seen = 0;
      for (i = 0; i < 7000 && seen < 3; i++)
      begin
         @(negedge clk);
         if (seen == 2)
            gap++;
         if ((sel ? ee_tick : tw_tick) === 1'b1)
            seen++;
      end
      chk_val(what, 16'(exp), 16'(gap));
   endtask

   task automatic t_ticks();
      reg_write(8'h25, 8'h00);
      tick_gap("fast two wire", 1'b0, 500);
      reg_write(8'h25, 8'h04);
      tick_gap("slow two wire", 1'b0, 2000);
      tick_gap("fast eeprom", 1'b1, 500);
      fuse_slow = 1'b1;
      tick_gap("slow eeprom", 1'b1, 2000);
   endtask

   // ------------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------------
   // Every input starts defined; reset is held for three cycles.
   initial
   begin
      {clk, reset_n, custom_en, reg_wr, reg_rd, fuse_slow} = '0;
      {str_req, auto_en, chg_start, chg_next} = '0;
      {reg_addr, reg_wdata, fuse_bits, str_index} = '0;
      ce = 1'b1;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      t_regs();
      t_freeze();
      t_reset();
      t_string();
      for (int b = 0; b < 4; b++)
         chg_seq(2'(b));
      t_ticks();
      close_out();
   end

   // Cuts a hang short well past the expected run length.
   initial
   begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      close_out();
   end
endmodule
`default_nettype wire
